/* File: cpc_pkg.sv */
package cpc_pkg;
   // Clock source field encodings
   localparam logic [1:0] CPC_SRC_MULT = 2'h0;
   localparam logic [1:0] CPC_SRC_RSVD = 2'h1;
   localparam logic [1:0] CPC_SRC_DIV4 = 2'h2;
   localparam logic [1:0] CPC_SRC_PMM  = 2'h3;
   localparam logic [1:0] CPC_SRC_RST  = CPC_SRC_DIV4;

   // Register offsets, used as word indices on the bus
   localparam logic [7:0] CPC_OFS_PMR    = 8'hc4;
   localparam logic [7:0] CPC_OFS_STATUS = 8'hc5;
   localparam logic [7:0] CPC_OFS_TA     = 8'hc7;
   localparam logic [7:0] CPC_OFS_POWER_CTRL_REG   = 8'h87;
   localparam logic [7:0] CPC_OFS_EXT_IRQ_FLAG_REG   = 8'h91;

   // Field positions
   localparam int CPC_PMR_CD_LO  = 6;
   localparam int CPC_PMR_SWB    = 5;
   localparam int CPC_PMR_CTM    = 4;
   localparam int CPC_PMR_MULT4  = 3;
   localparam int CPC_POWER_CTRL_REG_OSC_FAIL_FLAG  = 5;
   localparam int CPC_POWER_CTRL_REG_OSC_FAIL_DETECT_ENABLE  = 4;
   localparam int CPC_POWER_CTRL_REG_STOP  = 1;
   localparam int CPC_EXT_IRQ_FLAG_REG_RDY   = 4;
   localparam int CPC_EXT_IRQ_FLAG_REG_RING_OSC_ACTIVE  = 2;

   // Timed access keys and window length
   localparam logic [7:0] CPC_TA_KEY1 = 8'haa;
   localparam logic [7:0] CPC_TA_KEY2 = 8'h55;
   localparam logic [1:0] CPC_TA_WIN  = 2'h3;

   // Oscillator cycle counts, divider and clock frequencies
   localparam int CPC_LOCK_OSC     = 65536;
   localparam int CPC_PMM_OSC      = 1024;
   localparam int CPC_MC_DIV       = 4;
   localparam int CPC_CLK_MHZ      = 100;
   localparam int CPC_FAIL_KHZ     = 40;
   // Reference cycles without an oscillator edge that mean failure
   localparam int CPC_FAIL_CYC     = (CPC_CLK_MHZ * 1000) / CPC_FAIL_KHZ;

   // Bus request carrier
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } cpc_req_t;

   // Interrupt level activity carrier
   typedef struct packed {
      logic pf;
      logic hi;
      logic lo;
   } cpc_lvl_t;
endpackage

/* File: cpc_clock_power.sv */
`timescale 1ns/1ps
module cpc_clock_power
   import cpc_pkg::*;
(
   input  wire logic        ref_clk,          // System reference clock
   input  wire logic        sys_rst,          // Synchronous reset, active high
   input  wire logic        pwr_fail_rst,     // Power-fail reset pulse
   input  wire logic        osc_tick,         // One pulse per oscillator cycle
   input  wire logic        ring_osc_start,   // Stop exit via ring oscillator
   input  wire logic        stop_mode,        // Processor is in stop mode
   input  wire logic        irq_ack,          // Enabled unblocked interrupt acknowledged
   input  wire logic        uart_start_bit,   // Enabled UART saw a start bit
   input  wire logic        serial_tx_load,   // Transmit buffer written
   input  wire logic [1:0]  serial_active,    // Per-port serial activity
   input  wire cpc_lvl_t    lvl_in_service,   // Priority levels in service
   input  wire logic        haddr_sel,        // Unused select strap, keep low
   input  wire logic        hsel,             // AHB slave select
   input  wire logic [31:0] haddr,            // AHB address
   input  wire logic [1:0]  htrans,           // AHB transfer type
   input  wire logic        hwrite,           // AHB write
   input  wire logic [2:0]  hsize,            // AHB size
   input  wire logic [31:0] hwdata,           // AHB write data
   input  wire logic        hready,           // AHB bus ready
   output logic      [31:0] hrdata,           // AHB read data
   output logic             hreadyout,        // AHB slave ready
   output logic             hresp,            // AHB response, always OKAY
   output logic      [1:0]  clk_source,       // Active source selection
   output logic             multiply_factor_select, // Quadruple when set
   output logic             sys_clk_en,       // System clock enable pulse
   output logic             mach_cycle_en,    // Machine cycle enable pulse
   output logic             cpu_reset_hold    // Processor held in reset
);

   // Overview of the block
   // The source field written by software and the source in effect
   // are kept apart, so a legal write first becomes pending and only
   // reaches the divider at the next machine cycle boundary.
   // All slower rates are single-cycle enables on ref_clk; there is
   // no derived clock, which keeps the block in one timing domain.
   // The oscillator arrives as a tick pulse, one per crystal cycle,
   // already synchronous to ref_clk.
   // Multiplier rates cannot be shown faster than ref_clk, so both
   // factors give an enable on every reference cycle; the factor
   // bit is exported for the clock generator outside.

   // Registered control state
   logic [1:0]  cd_q;                    // Written source field
   logic [1:0]  act_q;                   // Source in effect
   logic        swb_q;                   // Switchback enable
   logic        ctm_q;                   // Multiplier enable
   logic        mult4_q;                 // Factor bit
   logic        rdy_q;                   // Multiplier ready flag
   logic        ring_osc_active_q;                  // Ring oscillator mode flag
   logic        osc_fail_detect_enable_q;                  // Fail detect enable
   logic        osc_fail_flag_q;                  // Fail flag
   logic        ctm_clr_seen_q;          // Sequence step: enable cleared
   logic [16:0] lock_cnt_q;              // Lock counter
   logic [16:0] ring_cnt_q;              // Ring exit counter
   logic [12:0] fail_cnt_q;              // Cycles since last osc edge
   logic [1:0]  ta_state_q;              // Timed access key progress
   logic [1:0]  ta_win_q;                // Window cycles left
   logic [9:0]  sys_div_q;               // Oscillator divider
   logic [1:0]  mc_div_q;                // Machine cycle divider
   logic        pend_q;                  // Pending rate change
   logic [1:0]  pend_src_q;              // Rate waiting to apply
   logic        dphase_q;                // Data phase active
   cpc_req_t    req_q;                   // Latched address phase

   // Combinational helpers
   logic        wr_pmr;                  // Write to mode register
   logic        wr_power_ctrl_reg;                 // Write to power control
   logic        wr_ta;                   // Write to timed access
   logic        wr_ext_irq_flag_reg;                 // Write to flag register
   logic [7:0]  wd;                      // Write data byte
   logic [1:0]  new_cd;                  // Requested source field
   logic        cd_ok;                   // Requested change legal
   logic        ta_open;                 // Window open
   logic        sb_event;                // Switchback trigger
   logic        osc_fail;                // Failure detected
   logic [7:0]  rd_byte;                 // Read mux
   logic [9:0]  div_lim;                 // Oscillator cycles per sys tick, less one

   // Bus front end
   // Only the low byte of each word carries a register; upper bits
   // read zero and are ignored on write.
   // The slave never stretches a transfer, so hreadyout is tied high
   // and the data phase always completes one edge after the address.
   // Write strobes below are qualified by the latched phase, so a
   // write lands at the edge that ends its data phase.

   // Address phase capture and zero-wait response
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dphase_q <= 1'b0;
         req_q    <= '0;
      end else if (hready) begin
         dphase_q   <= hsel & htrans[1];
         req_q.wr   <= hwrite;
         req_q.addr <= haddr[9:2] == 8'h00 ? 8'h00 : haddr[9:2];
         req_q.wdata <= 8'h00;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wd        = hwdata[7:0];
   // Word index equals documented offset
   assign wr_pmr  = dphase_q & req_q.wr & (req_q.addr == CPC_OFS_PMR);
   assign wr_power_ctrl_reg = dphase_q & req_q.wr & (req_q.addr == CPC_OFS_POWER_CTRL_REG);
   assign wr_ta   = dphase_q & req_q.wr & (req_q.addr == CPC_OFS_TA);
   assign wr_ext_irq_flag_reg = dphase_q & req_q.wr & (req_q.addr == CPC_OFS_EXT_IRQ_FLAG_REG);
   assign new_cd  = wd[CPC_PMR_CD_LO +: 2];

   // Source field write filter
   // Writing the current value again is always harmless and passes,
   // which lets software touch the other mode bits freely.
   // Serial lockout is checked before the transition rules so that a
   // busy port freezes the rate even for an otherwise legal change.
   // Engaging the multiplier needs the ordered steps recorded in
   // ctm_clr_seen_q plus a locked and settled oscillator.

   // Legality of a source field write
   always_comb begin
      cd_ok = 1'b0;
      if (new_cd == CPC_SRC_RSVD)
         cd_ok = 1'b0;
      else if (new_cd == cd_q)
         cd_ok = 1'b1;
      else if (|serial_active)
         cd_ok = 1'b0;
      else if (new_cd == CPC_SRC_MULT)
         cd_ok = (cd_q == CPC_SRC_DIV4) & ctm_clr_seen_q & ctm_q & rdy_q & ~ring_osc_active_q;
      else if (new_cd == CPC_SRC_PMM)
         cd_ok = (cd_q == CPC_SRC_DIV4);
      else
         cd_ok = 1'b1;
   end

   assign sb_event = swb_q & (cd_q == CPC_SRC_PMM)
                     & (irq_ack | uart_start_bit | serial_tx_load);

   // Mode register update
   // Switchback has priority over a software write in the same
   // cycle; the write is lost, and software sees divide-by-4.
   // The factor bit is frozen while the multiplier is enabled, so a
   // stray write cannot retune a running multiplier.
   // The sequence flag is armed by clearing the enable in divide-by-4
   // with ring mode off, and dropped by any other written source change; switchback leaves it unchanged.

   // Source field, switchback and multiplier controls
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cd_q           <= CPC_SRC_RST;
         swb_q          <= 1'b0;
         ctm_q          <= 1'b0;
         mult4_q        <= 1'b0;
         ctm_clr_seen_q <= 1'b0;
      end else if (sb_event) begin
         cd_q <= CPC_SRC_DIV4;
      end else if (wr_pmr) begin
         swb_q <= wd[CPC_PMR_SWB];
         if (cd_ok)
            cd_q <= new_cd;
         // Factor only changes while enable is off
         if (~ctm_q && cd_q == CPC_SRC_DIV4)
            mult4_q <= wd[CPC_PMR_MULT4];
         ctm_q <= wd[CPC_PMR_CTM];
         if (~wd[CPC_PMR_CTM] && cd_q == CPC_SRC_DIV4 && ~ring_osc_active_q)
            ctm_clr_seen_q <= 1'b1;
         else if (cd_ok && new_cd != cd_q)
            ctm_clr_seen_q <= 1'b0;
      end
   end

   // Lock timer
   // Dropping the enable restarts the count, so a ready flag always
   // means a full lock interval since the last enable.
   // The counter is wide enough to stop exactly at the interval.

   // Lock timer counts oscillator cycles while enabled
   always_ff @(posedge ref_clk) begin
      if (sys_rst || ~ctm_q) begin
         lock_cnt_q <= '0;
         rdy_q      <= 1'b0;
      end else if (osc_tick && !rdy_q) begin
         if (lock_cnt_q == 17'(CPC_LOCK_OSC - 1))
            rdy_q <= 1'b1;
         lock_cnt_q <= lock_cnt_q + 17'h1;
      end
   end

   // Ring mode tracking
   // Counts crystal ticks only, never ring cycles, so the flag clears
   // once the crystal has run long enough to be trusted.
   // A new stop exit restarts the interval from zero.

   // Ring oscillator mode flag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ring_osc_active_q     <= 1'b0;
         ring_cnt_q <= '0;
      end else if (ring_osc_start) begin
         ring_osc_active_q     <= 1'b1;
         ring_cnt_q <= '0;
      end else if (ring_osc_active_q && osc_tick) begin
         if (ring_cnt_q == 17'(CPC_LOCK_OSC - 1))
            ring_osc_active_q <= 1'b0;
         ring_cnt_q <= ring_cnt_q + 17'h1;
      end
   end

   // Timed access guard
   // Any other bus transfer between the keys aborts the sequence.
   // The window counts reference cycles, and one protected write
   // closes it at once, so two protected writes need two key pairs.
   // Limitation: the window is short enough that the protected write
   // must follow the second key directly on the bus.

   // Timed access key sequence and window
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ta_state_q <= 2'h0;
         ta_win_q   <= 2'h0;
      end else begin
         if (ta_win_q != 2'h0)
            ta_win_q <= ta_win_q - 2'h1;
         if (wr_ta && wd == CPC_TA_KEY1)
            ta_state_q <= 2'h1;
         else if (wr_ta && wd == CPC_TA_KEY2 && ta_state_q == 2'h1) begin
            ta_state_q <= 2'h0;
            ta_win_q   <= CPC_TA_WIN;
         end else if (dphase_q)
            ta_state_q <= 2'h0;
         if (wr_power_ctrl_reg && ta_open)
            ta_win_q <= 2'h0;                                // One bit per window
      end
   end

   assign ta_open = ta_win_q != 2'h0;

   // Oscillator loss detector
   // A gap longer than the threshold in reference cycles stands for
   // an oscillator below the failure frequency.
   // The count saturates, so the hold stays while the crystal is dead.
   // Stop mode clears it: a crystal halted on purpose is no failure.

   // Oscillator watchdog on the reference clock
   always_ff @(posedge ref_clk) begin
      if (sys_rst || osc_tick || stop_mode || ~osc_fail_detect_enable_q)
         fail_cnt_q <= '0;
      else if (fail_cnt_q != 13'(CPC_FAIL_CYC))
         fail_cnt_q <= fail_cnt_q + 13'h1;
   end

   assign osc_fail = osc_fail_detect_enable_q & ~stop_mode & (fail_cnt_q == 13'(CPC_FAIL_CYC));

   // Detector enable and failure record
   // The flag is not cleared by the ordinary reset on purpose: the
   // reset that the detector itself forces must not erase its cause.
   // A new failure wins over a software clear in the same cycle.

   // Fail detect enable and sticky fail flag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         osc_fail_detect_enable_q <= 1'b0;
      end else if (wr_power_ctrl_reg && ta_open) begin
         osc_fail_detect_enable_q <= wd[CPC_POWER_CTRL_REG_OSC_FAIL_DETECT_ENABLE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (pwr_fail_rst)
         osc_fail_flag_q <= 1'b0;
      else if (osc_fail)
         osc_fail_flag_q <= 1'b1;
      else if (wr_power_ctrl_reg && ~wd[CPC_POWER_CTRL_REG_OSC_FAIL_FLAG])
         osc_fail_flag_q <= 1'b0;
   end

   assign cpu_reset_hold = osc_fail;

   // Rate generation
   // Divide-by-4 passes every crystal tick as a system tick, and the
   // low rate lets one tick through in each group of many.
   // Divider state is kept across changes; the first divide-by-4 tick after
   // leaving the low rate may come late by nearly 1024 crystal ticks.

   // Oscillator divider gives system clock enable
   always_comb begin
      unique case (act_q)
         CPC_SRC_PMM:  div_lim = 10'(CPC_PMM_OSC / CPC_MC_DIV - 1);
         default:      div_lim = 10'h0;
      endcase
   end

   // System clock tick; multiplier rates run every reference cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sys_div_q  <= '0;
         sys_clk_en <= 1'b0;
      end else if (act_q == CPC_SRC_MULT) begin
         sys_clk_en <= 1'b1;
      end else if (osc_tick) begin
         sys_clk_en <= sys_div_q == div_lim;
         sys_div_q  <= sys_div_q == div_lim ? 10'h0 : sys_div_q + 10'h1;
      end else begin
         sys_clk_en <= 1'b0;
      end
   end

   // Machine cycle enable
   // Registered one cycle behind the system tick it counts; at the
   // multiplier rate the system tick is high on every edge, so the two pulses line up.

   // Machine cycle is every fourth system tick
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mc_div_q      <= '0;
         mach_cycle_en <= 1'b0;
      end else begin
         mach_cycle_en <= sys_clk_en && mc_div_q == 2'h3;
         if (sys_clk_en)
            mc_div_q <= mc_div_q + 2'h1;
      end
   end

   // Rate hand-over
   // Changing only at a machine cycle boundary avoids a short cycle
   // in the middle of an instruction.
   // A second write while one change is pending waits for it to land,
   // then is picked up at the following boundary.

   // Apply new rate at the first machine cycle boundary after the change turns pending
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         act_q      <= CPC_SRC_RST;
         pend_q     <= 1'b0;
         pend_src_q <= CPC_SRC_RST;
      end else begin
         if (cd_q != act_q && !pend_q) begin
            pend_q     <= 1'b1;
            pend_src_q <= cd_q;
         end else if (pend_q && mach_cycle_en) begin
            act_q  <= pend_src_q;
            pend_q <= 1'b0;
         end
      end
   end

   assign clk_source             = act_q;
   assign multiply_factor_select = mult4_q;

   // Register readback
   // Status reflects live inputs, so software sees levels and serial
   // activity as they are now, not latched at the address phase.
   // Unmapped addresses read zero.

   // Read mux; serial bits sit at 4:3
   always_comb begin
      unique case (req_q.addr)
         CPC_OFS_PMR:    rd_byte = {cd_q, swb_q, ctm_q, mult4_q, 3'h0};
         CPC_OFS_STATUS: rd_byte = {lvl_in_service.pf, lvl_in_service.hi,
                                    lvl_in_service.lo, serial_active, 3'h0};
         CPC_OFS_POWER_CTRL_REG:   rd_byte = {2'h0, osc_fail_flag_q, osc_fail_detect_enable_q, 4'h0};
         CPC_OFS_EXT_IRQ_FLAG_REG:   rd_byte = {3'h0, rdy_q, 1'b0, ring_osc_active_q, 2'h0};
         default:        rd_byte = 8'h00;
      endcase
   end

   assign hrdata = (dphase_q & ~req_q.wr) ? {24'h0, rd_byte} : 32'h0;

endmodule

/* File: cpc_osc_model.sv */
`timescale 1ns/1ps
// Crystal stand-in, one tick per reference cycle while running
module cpc_osc_model (
   input  wire logic ref_clk,  // Reference clock
   input  wire logic run,      // Low models a dead or halted crystal
   output logic      osc_tick  // Single-cycle oscillator pulses
);
   // Ticks stop dead when halted, no free edges
   always_ff @(posedge ref_clk) begin
      osc_tick <= run;
   end
endmodule

/* File: cpc_clock_power_assertions.sv */
`timescale 1ns/1ps
module cpc_clock_power_assertions
   import cpc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        pwr_fail_rst,
   input wire logic        osc_tick,
   input wire logic        stop_mode,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [1:0]  clk_source,
   input wire logic        sys_clk_en,
   input wire logic        mach_cycle_en,
   input wire logic        cpu_reset_hold
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic        dph_q;   // Data phase under way
   logic [15:0] idle_q;  // Cycles since last tick
   // Data phase follows an accepted address phase
   always_ff @(posedge ref_clk) begin
      dph_q <= !sys_rst && hsel && htrans[1] && hready;
   end
   // Saturating gap count, kept through stop so a frozen detector is not flagged
   always_ff @(posedge ref_clk) begin
      idle_q <= osc_tick ? 16'h0 : idle_q + {15'h0, ~&idle_q};
   end
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not OKAY");
   rd_idle_a: assert property (!dph_q |-> hrdata == 32'h0) else $error("read data outside data phase");
   rst_src_a: assert property ($fell(sys_rst) |-> clk_source == CPC_SRC_DIV4)
      else $error("source not divide-by-4 after reset");
   rsvd_never_a: assert property (clk_source != CPC_SRC_RSVD) else $error("reserved source active");
   via_div4_a: assert property ($changed(clk_source) |->
      $past(clk_source) == CPC_SRC_DIV4 || clk_source == CPC_SRC_DIV4) else $error("source skipped divide-by-4");
   mc_space_a: assert property (mach_cycle_en |=> !mach_cycle_en [*3]) else $error("machine cycle too short");
   mult_rate_a: assert property (clk_source == CPC_SRC_MULT && $past(clk_source) == CPC_SRC_MULT |-> sys_clk_en)
      else $error("multiplier rate wrong");
   fail_hold_a: assert property ($rose(cpu_reset_hold) |-> idle_q >= 16'(CPC_FAIL_CYC - 2) && !stop_mode)
      else $error("reset hold without oscillator loss");
   osc_back_a: assert property (cpu_reset_hold && osc_tick |=> !cpu_reset_hold) else $error("hold kept after oscillator return");
endmodule
bind cpc_clock_power cpc_clock_power_assertions i_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .pwr_fail_rst(pwr_fail_rst), .osc_tick(osc_tick),
   .stop_mode(stop_mode), .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .clk_source(clk_source), .sys_clk_en(sys_clk_en),
   .mach_cycle_en(mach_cycle_en), .cpu_reset_hold(cpu_reset_hold));

/* File: clock_power_control_tb.sv */
`timescale 1ns/1ps
module clock_power_control_tb;
   import cpc_pkg::*;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, pwr_fail_rst = 1'b1, run = 1'b1;
   logic        ring_osc_start = 1'b0, stop_mode = 1'b0, hwrite = 1'b0, osc_tick;
   logic [2:0]  ev = 3'h0;            // Switchback events
   logic [1:0]  serial_active = 2'h0, htrans = 2'h0, clk_source;
   cpc_lvl_t    lvl_in_service = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h2577;
   logic        irq_ack, uart_start_bit, serial_tx_load, hready, hreadyout, hresp;
   logic        multiply_factor_select, sys_clk_en, mach_cycle_en, cpu_reset_hold;
   logic [1:0]  src_m = CPC_SRC_DIV4; // Modelled source field
   logic        auto_speedup_enable = 1'b0, multiplier_enable = 1'b0, fac = 1'b0, rdy = 1'b0;
   logic [7:0]  d;
   int          mismatches = 0, comparisons = 0, cyc = 0, t0, n, i;
   assign {irq_ack, uart_start_bit, serial_tx_load} = ev;
   assign hready = hreadyout;  // Sole slave drives bus ready
   always #5 ref_clk = ~ref_clk;
   cpc_osc_model i_osc (.ref_clk(ref_clk), .run(run), .osc_tick(osc_tick));
   cpc_clock_power i_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .pwr_fail_rst(pwr_fail_rst), .osc_tick(osc_tick),
      .ring_osc_start(ring_osc_start), .stop_mode(stop_mode), .irq_ack(irq_ack),
      .uart_start_bit(uart_start_bit), .serial_tx_load(serial_tx_load), .serial_active(serial_active),
      .lvl_in_service(lvl_in_service), .haddr_sel(1'b0), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .clk_source(clk_source),
      .multiply_factor_select(multiply_factor_select), .sys_clk_en(sys_clk_en),
      .mach_cycle_en(mach_cycle_en), .cpu_reset_hold(cpu_reset_hold));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One single word transfer; register index times four is the byte address
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, a, 2'h0};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask
   // Two machine cycles cover the landing of any pending change
   task automatic settle();
      repeat (2) begin
         do @(posedge ref_clk); while (mach_cycle_en !== 1'b1);
      end
      #1;
   endtask
   // Source write checked against the field model
   task automatic power_mgmt_reg(input logic [1:0] s);
      logic [7:0] j;
      bus(1'b1, CPC_OFS_PMR, {s, auto_speedup_enable, multiplier_enable, fac, 3'h0}, j);
      if (s != CPC_SRC_RSVD && (src_m == CPC_SRC_DIV4 || s == CPC_SRC_DIV4) && serial_active == 2'h0
          && (s != CPC_SRC_MULT || rdy)) src_m = s;
      settle();
      chk(clk_source, src_m);
   endtask
   // Oscillator loss must hold the processor within the threshold plus 100 cycles
   task automatic fail_wait();
      n = 0;
      while (cpu_reset_hold !== 1'b1 && n < CPC_FAIL_CYC + 100) begin
         @(posedge ref_clk);
         n++;
      end
      chk(cpu_reset_hold, 1'b1);
   endtask
   // Cut a hang short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      pwr_fail_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(clk_source, CPC_SRC_DIV4);
      // Random levels and serial activity, source writes locked meanwhile
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         lvl_in_service <= seed[2:0];
         serial_active <= seed[4:3] | 2'h1;
         @(posedge ref_clk);
         bus(1'b0, CPC_OFS_STATUS, 8'h0, d);
         chk(d, {seed[2:0], seed[4:3] | 2'h1, 3'h0});
         power_mgmt_reg(CPC_SRC_PMM);
      end
      serial_active <= 2'h0;
      bus(1'b0, 8'h10, 8'h0, d);
      chk(d, 8'h0);
      power_mgmt_reg(CPC_SRC_RSVD);
      power_mgmt_reg(CPC_SRC_MULT);
      // Locked multiplier sequence, with an early engage attempt
      fac = 1'b1;
      power_mgmt_reg(CPC_SRC_DIV4);
      @(posedge ref_clk);
      ring_osc_start <= 1'b1;
      @(posedge ref_clk);
      ring_osc_start <= 1'b0;
      multiplier_enable = 1'b1;
      t0 = cyc;
      power_mgmt_reg(CPC_SRC_MULT);
      bus(1'b0, CPC_OFS_EXT_IRQ_FLAG_REG, 8'h0, d);
      chk(d[CPC_EXT_IRQ_FLAG_REG_RING_OSC_ACTIVE], 1'b1);
      while (d[CPC_EXT_IRQ_FLAG_REG_RDY] !== 1'b1) bus(1'b0, CPC_OFS_EXT_IRQ_FLAG_REG, 8'h0, d);
      chk(cyc - t0 > 65000 && cyc - t0 < 66100, 1);
      bus(1'b0, CPC_OFS_EXT_IRQ_FLAG_REG, 8'h0, d);
      chk(d[CPC_EXT_IRQ_FLAG_REG_RING_OSC_ACTIVE], 1'b0);
      rdy = 1'b1;
      power_mgmt_reg(CPC_SRC_MULT);
      chk(multiply_factor_select, 1'b1);
      power_mgmt_reg(CPC_SRC_PMM);
      power_mgmt_reg(CPC_SRC_DIV4);
      // Interrupt, start bit and transmit load, first with switchback off
      for (i = 0; i < 4; i++) begin
         auto_speedup_enable = (i != 0);
         power_mgmt_reg(CPC_SRC_PMM);
         @(posedge ref_clk);
         ev <= 3'h4 >> (i == 0 ? 0 : i - 1);
         @(posedge ref_clk);
         ev <= 3'h0;
         if (auto_speedup_enable) src_m = CPC_SRC_DIV4;
         settle();
         chk(clk_source, src_m);
         power_mgmt_reg(CPC_SRC_DIV4);
      end
      // Fail detect enable only through the timed window
      bus(1'b1, CPC_OFS_POWER_CTRL_REG, 8'h10, d);
      bus(1'b0, CPC_OFS_POWER_CTRL_REG, 8'h0, d);
      chk(d[5:4], 2'h0);
      bus(1'b1, CPC_OFS_TA, CPC_TA_KEY1, d);
      bus(1'b1, CPC_OFS_TA, CPC_TA_KEY2, d);
      bus(1'b1, CPC_OFS_POWER_CTRL_REG, 8'h10, d);
      bus(1'b0, CPC_OFS_POWER_CTRL_REG, 8'h0, d);
      chk(d[5:4], 2'h1);
      run <= 1'b0;
      stop_mode <= 1'b1;
      repeat (3000) @(posedge ref_clk);
      chk(cpu_reset_hold, 1'b0);
      stop_mode <= 1'b0;
      fail_wait();
      bus(1'b0, CPC_OFS_POWER_CTRL_REG, 8'h0, d);
      chk(d[5:4], 2'h3);
      run <= 1'b1;
      bus(1'b1, CPC_OFS_POWER_CTRL_REG, 8'h10, d);
      @(posedge ref_clk);
      #1;
      chk(cpu_reset_hold, 1'b0);
      run <= 1'b0;
      fail_wait();
      pwr_fail_rst <= 1'b1;
      run <= 1'b1;
      @(posedge ref_clk);
      pwr_fail_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(cpu_reset_hold, 1'b0);
      test_done();
   end
endmodule
